// *** hw/ubg_defs.svh ***
// register map, field positions, reset values and divider constants of the serial port baud/data block
// assumes a byte-wide register port and a 20 MHz system clock
//
// Summary of operation
// - the low eight bits of each received character are read from the read-only receive data register, the ninth bit from the receive status register.
// - received characters, ninth bit included, are double buffered so a finished character stays readable while the next one shifts in.
// - transmit data, ninth bit included, is double buffered and a new write is taken once the previous character has begun shifting.
// - a write to the low divisor byte restarts the baud counter at once.
// - a write to the high divisor byte restarts the baud counter at once.
// - with the 8-bit generator selected the high divisor byte is ignored in every mode.
// - the divisor n is the high divisor byte above the low divisor byte.
// - asynchronous, 8-bit, low speed gives a bit rate of clock / (64 (n+1)).
// - asynchronous, 16-bit, low speed gives a bit rate of clock / (16 (n+1)).
// - synchronous mode gives a bit clock of clock / (4 (n+1)) for any width and speed setting.
// - a set generator width bit selects the 16-bit generator, a clear one the 8-bit generator.
// - a set mode bit selects synchronous mode, a clear one asynchronous mode, which picks the baud formula.
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH

`define UBG_ADDR_RX_DATA   3'h0
`define UBG_ADDR_TX_DATA   3'h1
`define UBG_ADDR_DIV_LOW   3'h2
`define UBG_ADDR_DIV_HIGH  3'h3
`define UBG_ADDR_RX_STAT   3'h4
`define UBG_ADDR_TX_STAT   3'h5
`define UBG_ADDR_BAUD_CTL  3'h6

// receive status/control fields
`define UBG_RS_ENABLE      7
`define UBG_RS_NINE        6
`define UBG_RS_SINGLE      5
`define UBG_RS_CONT        4
`define UBG_RS_ADDR_DET    3
`define UBG_RS_FERR        2
`define UBG_RS_OERR        1
`define UBG_RS_BIT9        0
// transmit status/control fields
`define UBG_TS_CLK_SRC     7
`define UBG_TS_NINE        6
`define UBG_TS_ENABLE      5
`define UBG_TS_SYNC        4
`define UBG_TS_BREAK       3
`define UBG_TS_HIGH_SPEED  2
`define UBG_TS_SHIFT_EMPTY 1
`define UBG_TS_BIT9        0
// baud control fields
`define UBG_BC_RX_IDLE     6
`define UBG_BC_POLARITY    4
`define UBG_BC_WIDTH16     3
`define UBG_BC_WAKE        1
`define UBG_BC_AUTO_BAUD   0

`define UBG_BYTE_ZERO      8'h00
`define UBG_CHAR_ZERO      9'h000
`define UBG_DIV_ZERO       16'h0000
`define UBG_PRE_ZERO       6'h00
`define UBG_PRE_ONE        6'h01
// prescaler terminal counts: divide by 64, 16 and 4
`define UBG_PRE_LAST_64    6'h3F
`define UBG_PRE_LAST_16    6'h0F
`define UBG_PRE_LAST_4     6'h03
`define UBG_DIV_ONE        16'h0001
`define UBG_PER_ZERO       24'h00_0000
`define UBG_PER_ONE        24'h00_0001
// clocks per divisor step for each prescale choice, as period-check factors
`define UBG_PER_K64        24'h00_0040
`define UBG_PER_K16        24'h00_0010
`define UBG_PER_K4         24'h00_0004

`endif

// *** hw/ubg_pkg.sv ***
// types shared by the serial port baud/data block
// assumes ubg_defs.svh carries all numeric constants
package ubg_pkg;
    typedef logic [7:0] ubg_byte_t;
    typedef logic [8:0] ubg_char_t;
    typedef logic [15:0] ubg_div_t;
    // prescale choice, one-hot
    typedef enum logic [2:0] {
        UBG_RATE_DIV64 = 3'b001,
        UBG_RATE_DIV16 = 3'b010,
        UBG_RATE_DIV4  = 3'b100
    } ubg_rate_t;
endpackage

// *** hw/ubg_baud_gen.sv ***
// baud rate generator: divisor counter followed by a mode prescaler
// assumes restart is a one-cycle pulse from the register port
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_baud_gen (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              restart,
    input  wire ubg_pkg::ubg_div_t divisor,
    input  wire ubg_pkg::ubg_rate_t rate,
    output logic                   tick
);
    import ubg_pkg::*;

    ubg_div_t     div_cnt;
    ubg_div_t     next_div_cnt;
    logic [5:0]   pre_cnt;
    logic [5:0]   next_pre_cnt;
    logic [5:0]   pre_last;
    logic         div_done;

    always_comb begin
        case (rate)
            UBG_RATE_DIV64: pre_last = `UBG_PRE_LAST_64;
            UBG_RATE_DIV16: pre_last = `UBG_PRE_LAST_16;
            UBG_RATE_DIV4:  pre_last = `UBG_PRE_LAST_4;
            default:        pre_last = `UBG_PRE_LAST_64;
        endcase
    end

    // compare with >= so a mode change mid-count cannot run past the limit
    assign div_done = (div_cnt >= divisor);
    assign tick     = div_done && (pre_cnt >= pre_last);

    always_comb begin
        next_div_cnt = div_cnt + `UBG_DIV_ONE;
        next_pre_cnt = pre_cnt;
        if (restart) begin
            next_div_cnt = `UBG_DIV_ZERO;
            next_pre_cnt = `UBG_PRE_ZERO;
        end else if (div_done) begin
            next_div_cnt = `UBG_DIV_ZERO;
            next_pre_cnt = tick ? `UBG_PRE_ZERO : pre_cnt + `UBG_PRE_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= `UBG_DIV_ZERO;
            pre_cnt <= `UBG_PRE_ZERO;
        end else begin
            div_cnt <= next_div_cnt;
            pre_cnt <= next_pre_cnt;
        end
    end

    a_restart_clears: assert property (@(posedge clk) disable iff (rst)
        restart |=> (div_cnt == `UBG_DIV_ZERO && pre_cnt == `UBG_PRE_ZERO))
        else $error("baud counter not restarted");

endmodule // ubg_baud_gen

// *** hw/ubg_rx_buffer.sv ***
// receive holding buffer behind the shifter, with overrun detection
// assumes char_valid is a one-cycle pulse from the receive shifter
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_rx_buffer (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               char_valid,
    input  wire ubg_pkg::ubg_char_t char_data,
    input  wire logic               char_ferr,
    input  wire logic               cont_enable,
    input  wire logic               take,
    output ubg_pkg::ubg_char_t      hold_data,
    output logic                    hold_ferr,
    output logic                    full,
    output logic                    overrun
);
    import ubg_pkg::*;

    ubg_char_t next_hold_data;
    logic      next_hold_ferr;
    logic      next_full;
    logic      next_overrun;
    logic      accept;

    // a character that meets a full buffer is dropped, not written over the unread one
    assign accept = char_valid && (!full || take);

    always_comb begin
        next_hold_data = hold_data;
        next_hold_ferr = hold_ferr;
        next_full      = full && !take;
        next_overrun   = overrun && cont_enable;
        if (accept) begin
            next_hold_data = char_data;
            next_hold_ferr = char_ferr;
            next_full      = 1'b1;
        end
        if (char_valid && full && !take) begin
            next_overrun = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hold_data <= `UBG_CHAR_ZERO;
            hold_ferr <= 1'b0;
            full      <= 1'b0;
            overrun   <= 1'b0;
        end else begin
            hold_data <= next_hold_data;
            hold_ferr <= next_hold_ferr;
            full      <= next_full;
            overrun   <= next_overrun;
        end
    end

    a_hold_stable: assert property (@(posedge clk) disable iff (rst)
        (full && !take) |=> $stable(hold_data))
        else $error("held character changed before it was read");

endmodule // ubg_rx_buffer

// *** hw/ubg_top.sv ***
// serial port baud generator and double-buffered data registers
// assumes shifters outside: receive pulses RX_CHAR_VALID, transmit pulses TX_TAKE when it starts a character
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_top (
    input  wire logic               CLK,
    input  wire logic               RST,
    input  wire logic [2:0]         ADDR,
    input  wire ubg_pkg::ubg_byte_t WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output ubg_pkg::ubg_byte_t      RDATA,
    input  wire logic               RX_CHAR_VALID,
    input  wire ubg_pkg::ubg_char_t RX_CHAR_DATA,
    input  wire logic               RX_CHAR_FERR,
    input  wire logic               RX_IDLE,
    output logic                    RX_BUF_FULL,
    input  wire logic               TX_TAKE,
    input  wire logic               TX_SHIFT_EMPTY,
    output logic                    TX_CHAR_VALID,
    output ubg_pkg::ubg_char_t      TX_CHAR_DATA,
    output logic                    BIT_TICK,
    output logic                    SYNC_MODE
);
    import ubg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // register state
    ubg_byte_t div_low;
    ubg_byte_t div_high;
    ubg_byte_t rx_ctl;
    ubg_byte_t tx_ctl;
    ubg_byte_t baud_ctl;
    ubg_char_t tx_buf;
    logic      tx_full;
    ubg_byte_t next_div_low;
    ubg_byte_t next_div_high;
    ubg_byte_t next_rx_ctl;
    ubg_byte_t next_tx_ctl;
    ubg_byte_t next_baud_ctl;
    ubg_char_t next_tx_buf;
    logic      next_tx_full;
    ubg_byte_t next_rdata;

    logic wr_rx_ctl;
    logic wr_tx_data;
    logic wr_div_low;
    logic wr_div_high;
    logic wr_tx_ctl;
    logic wr_baud_ctl;
    logic rd_rx_data;

    assign wr_tx_data  = WR && (ADDR == `UBG_ADDR_TX_DATA);
    assign wr_div_low  = WR && (ADDR == `UBG_ADDR_DIV_LOW);
    assign wr_div_high = WR && (ADDR == `UBG_ADDR_DIV_HIGH);
    assign wr_rx_ctl   = WR && (ADDR == `UBG_ADDR_RX_STAT);
    assign wr_tx_ctl   = WR && (ADDR == `UBG_ADDR_TX_STAT);
    assign wr_baud_ctl = WR && (ADDR == `UBG_ADDR_BAUD_CTL);
    assign rd_rx_data  = RD && (ADDR == `UBG_ADDR_RX_DATA);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // mode decode and divisor
    logic      width16;
    logic      high_speed;
    ubg_div_t  divisor;
    ubg_rate_t rate;

    assign width16    = baud_ctl[`UBG_BC_WIDTH16];
    assign high_speed = tx_ctl[`UBG_TS_HIGH_SPEED];
    assign SYNC_MODE  = tx_ctl[`UBG_TS_SYNC];
    // high byte forced off with the 8-bit generator
    assign divisor    = width16 ? {div_high, div_low} : {`UBG_BYTE_ZERO, div_low};

    always_comb begin
        if (SYNC_MODE) begin
            rate = UBG_RATE_DIV4;
        end else if (width16 && high_speed) begin
            rate = UBG_RATE_DIV4;
        end else if (width16 || high_speed) begin
            rate = UBG_RATE_DIV16;
        end else begin
            rate = UBG_RATE_DIV64;
        end
    end

    ubg_baud_gen u_baud (
        .clk     (CLK),
        .rst     (RST),
        .restart (wr_div_low || wr_div_high),
        .divisor (divisor),
        .rate    (rate),
        .tick    (BIT_TICK)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // receive side
    ubg_char_t rx_hold;
    logic      rx_ferr;
    logic      rx_oerr;

    ubg_rx_buffer u_rx (
        .clk         (CLK),
        .rst         (RST),
        .char_valid  (RX_CHAR_VALID),
        .char_data   (RX_CHAR_DATA),
        .char_ferr   (RX_CHAR_FERR),
        .cont_enable (rx_ctl[`UBG_RS_CONT]),
        .take        (rd_rx_data),
        .hold_data   (rx_hold),
        .hold_ferr   (rx_ferr),
        .full        (RX_BUF_FULL),
        .overrun     (rx_oerr)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // register writes and transmit buffer
    always_comb begin
        next_div_low  = wr_div_low ? WDATA : div_low;
        next_div_high = wr_div_high ? WDATA : div_high;
        next_rx_ctl   = wr_rx_ctl ? WDATA : rx_ctl;
        next_tx_ctl   = wr_tx_ctl ? WDATA : tx_ctl;
        next_baud_ctl = wr_baud_ctl ? WDATA : baud_ctl;
        next_tx_buf   = tx_buf;
        // a write in the same cycle as the shifter takes the old one keeps the buffer full
        next_tx_full  = tx_full && !TX_TAKE;
        if (wr_tx_ctl) begin
            next_tx_buf[8] = WDATA[`UBG_TS_BIT9];
        end
        if (wr_tx_data) begin
            next_tx_buf[7:0] = WDATA;
            next_tx_full     = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            div_low  <= `UBG_BYTE_ZERO;
            div_high <= `UBG_BYTE_ZERO;
            rx_ctl   <= `UBG_BYTE_ZERO;
            tx_ctl   <= `UBG_BYTE_ZERO;
            baud_ctl <= `UBG_BYTE_ZERO;
            tx_buf   <= `UBG_CHAR_ZERO;
            tx_full  <= 1'b0;
        end else begin
            div_low  <= next_div_low;
            div_high <= next_div_high;
            rx_ctl   <= next_rx_ctl;
            tx_ctl   <= next_tx_ctl;
            baud_ctl <= next_baud_ctl;
            tx_buf   <= next_tx_buf;
            tx_full  <= next_tx_full;
        end
    end

    assign TX_CHAR_VALID = tx_full;
    assign TX_CHAR_DATA  = tx_buf;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // read port: data stands one cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = `UBG_BYTE_ZERO;
        if (RD) begin
            case (ADDR)
                `UBG_ADDR_RX_DATA:  next_rdata = rx_hold[7:0];
                `UBG_ADDR_TX_DATA:  next_rdata = tx_buf[7:0];
                `UBG_ADDR_DIV_LOW:  next_rdata = div_low;
                `UBG_ADDR_DIV_HIGH: next_rdata = div_high;
                `UBG_ADDR_RX_STAT: begin
                    next_rdata = rx_ctl;
                    next_rdata[`UBG_RS_FERR] = rx_ferr;
                    next_rdata[`UBG_RS_OERR] = rx_oerr;
                    next_rdata[`UBG_RS_BIT9] = rx_hold[8];
                end
                `UBG_ADDR_TX_STAT: begin
                    next_rdata = tx_ctl;
                    next_rdata[`UBG_TS_SHIFT_EMPTY] = TX_SHIFT_EMPTY;
                    next_rdata[`UBG_TS_BIT9]        = tx_buf[8];
                end
                `UBG_ADDR_BAUD_CTL: begin
                    next_rdata = baud_ctl;
                    next_rdata[`UBG_BC_RX_IDLE] = RX_IDLE;
                end
                default: next_rdata = `UBG_BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= `UBG_BYTE_ZERO;
        end else begin
            RDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // checking helpers: cycles between bit ticks with settings untouched
    logic [23:0] since_tick;
    logic [23:0] next_since_tick;
    logic        period_ok;
    logic        next_period_ok;
    logic        cfg_write;
    logic [23:0] div_plus;

    assign cfg_write = wr_div_low || wr_div_high || wr_tx_ctl || wr_baud_ctl;
    assign div_plus  = {`UBG_BYTE_ZERO, divisor} + `UBG_PER_ONE;

    always_comb begin
        next_since_tick = (BIT_TICK || cfg_write) ? `UBG_PER_ZERO : since_tick + `UBG_PER_ONE;
        next_period_ok  = cfg_write ? 1'b0 : (BIT_TICK ? 1'b1 : period_ok);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            since_tick <= `UBG_PER_ZERO;
            period_ok  <= 1'b0;
        end else begin
            since_tick <= next_since_tick;
            period_ok  <= next_period_ok;
        end
    end

    a_rate_async_64: assert property (@(posedge CLK) disable iff (RST)
        (BIT_TICK && period_ok && !SYNC_MODE && !width16 && !high_speed) |-> (since_tick + `UBG_PER_ONE == div_plus * `UBG_PER_K64))
        else $error("async 8-bit low speed period wrong");
    a_rate_async_w16: assert property (@(posedge CLK) disable iff (RST)
        (BIT_TICK && period_ok && !SYNC_MODE && width16 && !high_speed) |-> (since_tick + `UBG_PER_ONE == div_plus * `UBG_PER_K16))
        else $error("async 16-bit low speed period wrong");
    a_rate_sync_4: assert property (@(posedge CLK) disable iff (RST)
        (BIT_TICK && period_ok && SYNC_MODE) |-> (since_tick + `UBG_PER_ONE == div_plus * `UBG_PER_K4))
        else $error("sync period wrong");
    a_rate_async_hs8: assert property (@(posedge CLK) disable iff (RST)
        (BIT_TICK && period_ok && !SYNC_MODE && !width16 && high_speed) |-> (since_tick + `UBG_PER_ONE == div_plus * `UBG_PER_K16))
        else $error("async 8-bit high speed period wrong");
    a_rate_async_hs16: assert property (@(posedge CLK) disable iff (RST)
        (BIT_TICK && period_ok && !SYNC_MODE && width16 && high_speed) |-> (since_tick + `UBG_PER_ONE == div_plus * `UBG_PER_K4))
        else $error("async 16-bit high speed period wrong");
    a_high_ignored: assert property (@(posedge CLK) disable iff (RST)
        (!width16 && $changed(div_high) && !$past(wr_div_low)) |-> (divisor == {`UBG_BYTE_ZERO, div_low}))
        else $error("high divisor byte used in 8-bit mode");
    a_divisor_pair: assert property (@(posedge CLK) disable iff (RST)
        (wr_div_high && width16 && !wr_baud_ctl && !wr_div_low) |=> (divisor[15:8] == $past(WDATA)))
        else $error("divisor high byte not in upper bits");
    a_width_mode: assert property (@(posedge CLK) disable iff (RST)
        (wr_baud_ctl && !WDATA[`UBG_BC_WIDTH16] && !wr_tx_ctl) |=> (divisor[15:8] == `UBG_BYTE_ZERO))
        else $error("width bit clear still uses high byte");
    a_rx_read_data: assert property (@(posedge CLK) disable iff (RST)
        (rd_rx_data) |=> (RDATA == $past(rx_hold[7:0])))
        else $error("receive data read mismatch");
    a_tx_accept: assert property (@(posedge CLK) disable iff (RST)
        (wr_tx_data) |=> (TX_CHAR_VALID && TX_CHAR_DATA[7:0] == $past(WDATA)))
        else $error("transmit write not taken");
    // the shortest restarted period is four cycles, so no tick may follow within three
    a_high_restart: assert property (@(posedge CLK) disable iff (RST)
        (wr_div_high) |=> !BIT_TICK [*3])
        else $error("high byte write did not restart");

    c_rx_overrun: cover property (@(posedge CLK) disable iff (RST) RX_CHAR_VALID && RX_BUF_FULL && !rd_rx_data);
    c_tx_back_to_back: cover property (@(posedge CLK) disable iff (RST) TX_TAKE ##1 wr_tx_data);
    c_tick_sync: cover property (@(posedge CLK) disable iff (RST) BIT_TICK && period_ok && SYNC_MODE);
    c_tick_async64: cover property (@(posedge CLK) disable iff (RST) BIT_TICK && period_ok && rate == UBG_RATE_DIV64);

endmodule // ubg_top

// *** test/ubg_line_model.sv ***
// far side of the serial port: receive shifter pulses and transmit shifter that loads buffered characters
// assumes the bench calls send_char and sets stall; ubg_top drives the transmit buffer outputs
`timescale 1ns/1ps
module ubg_line_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               tx_char_valid,
    input  wire ubg_pkg::ubg_char_t tx_char_data,
    output logic                    rx_char_valid,
    output ubg_pkg::ubg_char_t      rx_char_data,
    output logic                    rx_char_ferr,
    output logic                    rx_idle,
    output logic                    tx_take,
    output logic                    tx_shift_empty
);
    import ubg_pkg::*;
    logic      stall;
    ubg_char_t got;
    int        busy;
    initial begin
        rx_char_valid = 1'b0;
        rx_char_data  = 9'h000;
        rx_char_ferr  = 1'b0;
        rx_idle       = 1'b1;
        stall         = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // data is inverted once the pulse is gone so a stale value never looks valid
    task automatic send_char(input ubg_char_t d, input logic ferr);
        @(posedge clk);
        rx_char_valid <= 1'b1;
        rx_char_data  <= d;
        rx_char_ferr  <= ferr;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rx_char_data  <= ~d;
        rx_char_ferr  <= ~ferr;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // shifter stays busy ten cycles per character; stall holds off the load
    always @(posedge clk) begin
        if (rst) begin
            tx_take        <= 1'b0;
            tx_shift_empty <= 1'b1;
            busy           <= 0;
        end else begin
            tx_take <= 1'b0;
            if (busy != 0) busy <= busy - 1;
            if (busy == 1) tx_shift_empty <= 1'b1;
            if (tx_char_valid === 1'b1 && tx_shift_empty && !tx_take && !stall) begin
                tx_take        <= 1'b1;
                got            <= tx_char_data;
                busy           <= 10;
                tx_shift_empty <= 1'b0;
            end
        end
    end
endmodule // ubg_line_model

// *** test/ubg_top_test.sv ***
// self-checking bench for ubg_top: registers, receive and transmit buffers, baud ticks in every mode
// assumes ubg_line_model stands in for the shifters
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_top_test;
    import ubg_pkg::*;
    logic clk, rst, wr, rd;
    logic [2:0] addr;
    ubg_byte_t wdata, rdata, v;
    logic rx_valid, rx_ferr, rx_idle, rx_full, tx_take, tx_empty, tx_valid, tick, sync_mode;
    ubg_char_t rx_data, tx_data;
    int errors = 0;
    int total_checks = 0;
    ubg_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .RX_CHAR_VALID(rx_valid), .RX_CHAR_DATA(rx_data), .RX_CHAR_FERR(rx_ferr), .RX_IDLE(rx_idle),
        .RX_BUF_FULL(rx_full), .TX_TAKE(tx_take), .TX_SHIFT_EMPTY(tx_empty), .TX_CHAR_VALID(tx_valid),
        .TX_CHAR_DATA(tx_data), .BIT_TICK(tick), .SYNC_MODE(sync_mode));
    ubg_line_model line (.clk(clk), .rst(rst), .tx_char_valid(tx_valid), .tx_char_data(tx_data),
        .rx_char_valid(rx_valid), .rx_char_data(rx_data), .rx_char_ferr(rx_ferr), .rx_idle(rx_idle),
        .tx_take(tx_take), .tx_shift_empty(tx_empty));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input ubg_byte_t d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0; wdata <= ~d;
    endtask
    task automatic rd_reg(input logic [2:0] a, output ubg_byte_t d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // cycles from the last edge to the next tick, bounded
    task automatic tick_gap(input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (tick !== 1'b1 && n < lim);
    endtask
    task automatic wait_take(input int lim);
        int n;
        n = 0;
        while (tx_take !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_map;
        for (int a = 0; a < 8; a++) begin
            if (a == 4 || a == 5 || a == 6) continue;
            rd_reg(a[2:0], v);
            chk("reset value", 16'h0000, {8'h00, v});
        end
        wr_reg(3'h7, 8'hA5);
        rd_reg(3'h7, v);
        chk("unmapped read", 16'h0000, {8'h00, v});
    endtask
    task automatic t_receive;
        line.send_char(9'h1A5, 1'b0);
        #1 chk("rx full", 16'h0001, {15'h0000, rx_full});
        line.send_char(9'h05A, 1'b0);
        repeat (5) @(posedge clk);
        rd_reg(`UBG_ADDR_RX_STAT, v);
        chk("rx ninth bit", 16'h0001, {15'h0000, v[`UBG_RS_BIT9]});
        rd_reg(`UBG_ADDR_RX_DATA, v);
        chk("rx data", 16'h00A5, {8'h00, v});
        #1 chk("rx full after read", 16'h0000, {15'h0000, rx_full});
    endtask
    task automatic t_transmit;
        line.stall = 1'b1;
        wr_reg(`UBG_ADDR_TX_STAT, 8'h01);
        wr_reg(`UBG_ADDR_TX_DATA, 8'h3C);
        #1 chk("tx buffer", 16'h033C, {6'h00, tx_valid, tx_data});
        line.stall = 1'b0;
        wait_take(20);
        chk("tx loaded", 16'h013C, {7'h00, line.got});
        wr_reg(`UBG_ADDR_TX_STAT, 8'h00);
        wr_reg(`UBG_ADDR_TX_DATA, 8'hC3);
        #1 chk("tx second while shifting", 16'h02C3, {6'h00, tx_valid, tx_data});
        rd_reg(`UBG_ADDR_TX_STAT, v);
        chk("shifter busy flag", 16'h0000, {15'h0000, v[`UBG_TS_SHIFT_EMPTY]});
        wait_take(40);
        chk("tx second loaded", 16'h00C3, {7'h00, line.got});
        chk("tx buffer empty", 16'h0000, {15'h0000, tx_valid});
    endtask
    // the last divisor write restarts the count; counted from that edge the first gap is one short of the period
    task automatic t_baud(input ubg_byte_t ctl, input ubg_byte_t ts, input logic hi_last, input int exp);
        int n;
        wr_reg(`UBG_ADDR_BAUD_CTL, ctl);
        wr_reg(`UBG_ADDR_TX_STAT, ts);
        if (hi_last) wr_reg(`UBG_ADDR_DIV_LOW, 8'h02);
        wr_reg(`UBG_ADDR_DIV_HIGH, 8'h01);
        if (!hi_last) wr_reg(`UBG_ADDR_DIV_LOW, 8'h02);
        tick_gap(exp + 4, n);
        chk("first tick after restart", exp[15:0] - 16'h0001, n[15:0]);
        tick_gap(exp + 4, n);
        chk("tick period", exp[15:0], n[15:0]);
        chk("sync mode pin", {15'h0000, ts[`UBG_TS_SYNC]}, {15'h0000, sync_mode});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 8'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset_map();
        t_receive();
        t_transmit();
        t_baud(8'h00, 8'h00, 1'b0, 192);
        t_baud(8'h00, 8'h04, 1'b0, 48);
        t_baud(8'h08, 8'h00, 1'b0, 4144);
        t_baud(8'h08, 8'h04, 1'b1, 1036);
        t_baud(8'h00, 8'h10, 1'b0, 12);
        t_baud(8'h08, 8'h14, 1'b1, 1036);
        rd_reg(`UBG_ADDR_DIV_HIGH, v);
        chk("divisor high readback", 16'h0001, {8'h00, v});
        finish_test();
    end
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule // ubg_top_test
